/* File: logic/dsp_pkg.sv */
package dsp_pkg;
   // Bus geometry: byte address, register index is address bits above the lane bits
   localparam int ADDR_W = 18;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 16;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_STATUS = 16'hC028;
   localparam logic [15:0] IDX_DATA_LOW = 16'hC029;
   localparam logic [15:0] IDX_DATA_HIGH = 16'hC02A;
   localparam logic [15:0] IDX_DIVIDER = 16'hC02B;
   // Status bit positions
   localparam int ST_TX_SHIFT = 0;
   localparam int ST_TX_FULL = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_RX_ORUN = 3;
   // Divider layout and reset value
   localparam logic [15:0] DIV_RESET = 16'h0000;
   localparam int D1_LSB = 8;
   localparam int D2_LSB = 0;
   localparam int BYTE_W = 8;
   localparam logic [7:0] D2_MIN = 8'h06;
   // Frame shape: start, eight data bits, stop
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] TX_SHIFTS = 4'h9;
   // Receiver states
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dsp_rx_state_t;
   // True when a tick counter has reached its limit
   function automatic logic dsp_count_done(input logic [7:0] cnt, input logic [7:0] lim);
      return (9'(cnt) + 9'h001) >= 9'(lim);
   endfunction
endpackage

/* File: logic/dsp_tick_if.sv */
`timescale 1ns/100ps
interface dsp_tick_if;
   // Output of the first divider stage, one cycle wide
   logic sample_tick;
   // Second divider: sample ticks per bit
   logic [7:0] bit_len;
   modport src (output sample_tick, output bit_len);
   modport sink (input sample_tick, input bit_len);
endinterface

/* File: logic/dsp_tx.sv */
`timescale 1ns/100ps
module dsp_tx
   import dsp_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bit timing
   dsp_tick_if.sink tick,
   // Load request from the register side
   input wire logic load,
   input wire logic [7:0] load_byte,
   // Shifter state and line
   output logic busy,
   output logic line
);
   logic [8:0] shift; // Data bits then stop bit
   logic [3:0] left; // Bit periods still to send after the current one
   logic [7:0] cnt; // Sample ticks in the current bit

   ////////////////////////////////////////////////////////////////////////
   // Frame shifter; a load while busy is never issued by the owner
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         line <= 1'b1;
         shift <= '0;
         left <= '0;
         cnt <= '0;
      end
      else if (load && !busy)
      begin
         // Start bit goes out at once
         busy <= 1'b1;
         line <= 1'b0;
         shift <= {1'b1, load_byte};
         left <= TX_SHIFTS;
         cnt <= '0;
      end
      else if (busy && tick.sample_tick)
      begin
         if (dsp_count_done(cnt, tick.bit_len))
         begin
            cnt <= '0;
            if (left == '0)
            begin
               // Stop bit done, line rests high
               busy <= 1'b0;
               line <= 1'b1;
            end
            else
            begin
               // LSB first, stop bit last
               line <= shift[0];
               shift <= {1'b0, shift[8:1]};
               left <= left - 4'h1;
            end
         end
         else
            cnt <= cnt + 8'h01;
      end
   end
endmodule

/* File: logic/dsp_rx.sv */
`timescale 1ns/100ps
module dsp_rx
   import dsp_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Sampling clock from the first divider
   dsp_tick_if.sink tick,
   // Already synchronised line
   input wire logic line,
   // Completed byte
   output logic done,
   output logic [7:0] data
);
   dsp_rx_state_t state; // Receiver phase
   logic prev; // Line one cycle ago, for the falling edge
   logic [7:0] cnt; // Sample ticks since last sample point
   logic [3:0] idx; // Data bits taken

   ////////////////////////////////////////////////////////////////////////
   // Edge history
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         prev <= 1'b1;
      else
         prev <= line;
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive sequence, timed in sample ticks
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state <= RX_IDLE;
         cnt <= '0;
         idx <= '0;
         data <= '0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         unique case (state)
            RX_IDLE:
               // High to low transition marks a start bit
               if (prev && !line)
               begin
                  state <= RX_START;
                  cnt <= '0;
               end
            RX_START:
               if (tick.sample_tick)
               begin
                  // Half a bit to reach mid start; a glitch returns to idle
                  if (dsp_count_done(cnt, tick.bit_len >> 1))
                  begin
                     state <= line ? RX_IDLE : RX_DATA;
                     cnt <= '0;
                     idx <= '0;
                  end
                  else
                     cnt <= cnt + 8'h01;
               end
            RX_DATA:
               if (tick.sample_tick)
               begin
                  if (dsp_count_done(cnt, tick.bit_len))
                  begin
                     // Mid-bit sample, shifted in LSB first
                     data <= {line, data[7:1]};
                     cnt <= '0;
                     idx <= idx + 4'h1;
                     if (idx == DATA_BITS - 4'h1)
                        state <= RX_STOP;
                  end
                  else
                     cnt <= cnt + 8'h01;
               end
            RX_STOP:
               if (tick.sample_tick)
               begin
                  if (dsp_count_done(cnt, tick.bit_len))
                  begin
                     // Low stop bit drops the byte silently
                     done <= line;
                     state <= RX_IDLE;
                     cnt <= '0;
                  end
                  else
                     cnt <= cnt + 8'h01;
               end
         endcase
      end
   end
endmodule

/* File: logic/dsp_serial.sv */
`timescale 1ns/100ps
// Contract
// - Overrun set on transfer over unread data
// - Status bit 2 shows unread received byte
// - Status bit 1 shows transmit register occupied
// - Status bit 0 shows frame being shifted
// - Low data read: byte low, clears full
// - Receive interrupt on every byte transfer
// - Low write sends at once when idle
// - Busy write holds byte, sets full flag
// - High data register uses bits 15:8
// - Divider: first high byte, second low
// - Divider resets to zero
// - Bit rate is clock over (D1+1)*D2
// - Receiver samples on first stage output
// - Start on falling edge, mid-bit, LSB first
// - Good stop bit delivers byte and flags
// - Transmit register empties as sending starts
// - Frame: start, eight bits, high stop
module dsp_serial
   import dsp_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Serial line
   input wire logic serial_rx_in,
   output logic serial_tx_out,
   // Interrupt requests, one-cycle pulses
   output logic transmit_irq,
   output logic receive_irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   dsp_tick_if tick (); // Shared bit timing
   logic rx_meta; // First synchroniser stage
   logic rx_sync; // Second synchroniser stage
   logic [15:0] bit_rate_divider; // Both divider stages
   logic [7:0] first_divider; // High byte
   logic [7:0] second_divider; // Low byte
   logic [7:0] stage1_cnt; // First stage counter
   logic ack; // Second cycle of a bus request
   logic [IDX_W-1:0] idx; // Register index from the byte address
   logic hit_status; // Decodes
   logic hit_low;
   logic hit_high;
   logic hit_div;
   logic wr_acc; // Write taken this edge
   logic rd_acc; // Read taken this edge
   logic data_wr; // Write of a byte for sending
   logic [7:0] data_wr_byte; // Byte picked from the right lane
   logic data_rd; // Read of received data
   logic tx_full_flag; // Transmit data register occupied
   logic [7:0] tx_hold; // Transmit data register
   logic tx_shifting_flag; // Shifter busy
   logic tx_start; // Byte moves to the shifter
   logic [7:0] tx_byte; // Byte handed to the shifter
   logic rx_done; // Byte completed by the receiver
   logic [7:0] rx_byte; // Byte from the receiver
   logic rx_full_flag; // Unread byte present
   logic rx_overrun_flag; // Last transfer overwrote data
   logic [7:0] rx_data; // Receive data register
   logic rx_stale; // Byte arrived after read data was captured
   logic [3:0] serial_status; // Assembled status
   logic [31:0] next_readdata; // Read mux

   ////////////////////////////////////////////////////////////////////////
   // Receive pin synchroniser; only the second stage is read
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end
      else
      begin
         rx_meta <= serial_rx_in;
         rx_sync <= rx_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider fields
   assign first_divider = bit_rate_divider[D1_LSB +: BYTE_W];
   assign second_divider = bit_rate_divider[D2_LSB +: BYTE_W];

   // First stage: one tick every D1+1 clocks
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         stage1_cnt <= '0;
         tick.sample_tick <= 1'b0;
      end
      else if (stage1_cnt >= first_divider)
      begin
         // Wrap; also catches a divider lowered under the count
         stage1_cnt <= '0;
         tick.sample_tick <= 1'b1;
      end
      else
      begin
         stage1_cnt <= stage1_cnt + 8'h01;
         tick.sample_tick <= 1'b0;
      end
   end

   // Second stage length is counted inside each shifter, so each frame
   // starts on its own phase rather than on a free-running bit clock
   assign tick.bit_len = second_divider;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: every request answers on its second cycle
   assign waitrequest = (read || write) && !ack;
   assign wr_acc = write && ack;
   assign rd_acc = read && ack;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ack <= 1'b0;
      else
         ack <= (read || write) && !ack;
   end

   // Address decode, low lane bits ignored
   assign idx = address[IDX_LSB +: IDX_W];
   assign hit_status = (idx == IDX_STATUS);
   assign hit_low = (idx == IDX_DATA_LOW);
   assign hit_high = (idx == IDX_DATA_HIGH);
   assign hit_div = (idx == IDX_DIVIDER);

   // Data writes: lane 0 for the low register, lane 1 for the high one
   assign data_wr = wr_acc && ((hit_low && byteenable[0]) || (hit_high && byteenable[1]));
   assign data_wr_byte = hit_high ? writedata[15:8] : writedata[7:0];
   assign data_rd = rd_acc && (hit_low || hit_high);

   ////////////////////////////////////////////////////////////////////////
   // Divider register, byte lanes honoured
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         bit_rate_divider <= DIV_RESET;
      else if (wr_acc && hit_div)
      begin
         // Values of D2 under the minimum are stored as written;
         // the line then runs too fast to be usable
         if (byteenable[0])
            bit_rate_divider[D2_LSB +: BYTE_W] <= writedata[D2_LSB +: BYTE_W];
         if (byteenable[1])
            bit_rate_divider[D1_LSB +: BYTE_W] <= writedata[D1_LSB +: BYTE_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit side: idle shifter takes the byte directly, otherwise hold it
   assign tx_start = (tx_full_flag || data_wr) && !tx_shifting_flag;
   assign tx_byte = tx_full_flag ? tx_hold : data_wr_byte;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         tx_full_flag <= 1'b0;
         tx_hold <= '0;
      end
      else if (tx_start)
         // Register empties the moment sending begins
         tx_full_flag <= 1'b0;
      else if (data_wr && !tx_full_flag)
      begin
         // Busy shifter: park the byte
         tx_full_flag <= 1'b1;
         tx_hold <= data_wr_byte;
      end
      // A write while full is dropped; software must wait
   end

   dsp_tx u_tx (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(tick.sink),
      .load(tx_start),
      .load_byte(tx_byte),
      .busy(tx_shifting_flag),
      .line(serial_tx_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Receiver
   dsp_rx u_rx (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(tick.sink),
      .line(rx_sync),
      .done(rx_done),
      .data(rx_byte)
   );

   // Receive data register and flags; an arriving byte wins over a read
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rx_data <= '0;
         rx_full_flag <= 1'b0;
         rx_overrun_flag <= 1'b0;
      end
      else if (rx_done)
      begin
         rx_data <= rx_byte;
         rx_overrun_flag <= rx_full_flag;
         rx_full_flag <= 1'b1;
      end
      else if (data_rd && !rx_stale)
         // Only clear if the byte returned is the one held
         rx_full_flag <= 1'b0;
   end

   // Marks a byte that landed after read data was captured, so its read
   // does not clear the flag of a byte software never saw
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rx_stale <= 1'b0;
      else if (rx_done)
         rx_stale <= 1'b1;
      else if ((read || write) && !ack)
         rx_stale <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt pulses, registered
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         transmit_irq <= 1'b0;
         receive_irq <= 1'b0;
      end
      else
      begin
         transmit_irq <= tx_start;
         receive_irq <= rx_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status and read mux; status writes fall through unused
   always_comb
   begin
      serial_status = '0;
      serial_status[ST_TX_SHIFT] = tx_shifting_flag;
      serial_status[ST_TX_FULL] = tx_full_flag;
      serial_status[ST_RX_FULL] = rx_full_flag;
      serial_status[ST_RX_ORUN] = rx_overrun_flag;
   end

   always_comb
   begin
      next_readdata = '0;
      if (hit_status)
         next_readdata[3:0] = serial_status;
      else if (hit_low)
         next_readdata[7:0] = rx_data;
      else if (hit_high)
         next_readdata[15:8] = rx_data;
      else if (hit_div)
         next_readdata[15:0] = bit_rate_divider;
   end

   // Captured on the first cycle, stands through the answering edge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         readdata <= '0;
      else if (read && !ack)
         readdata <= next_readdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   overrun_copy_a: assert property (rx_done |=> rx_overrun_flag == $past(rx_full_flag))
      else $error("overrun flag not copied from full flag");
   rx_full_set_a: assert property (rx_done |=> rx_full_flag && rx_data == $past(rx_byte))
      else $error("received byte not stored as full");
   tx_park_a: assert property (data_wr && tx_shifting_flag && !tx_full_flag |=> tx_full_flag)
      else $error("busy write did not set transmit full");
   tx_running_a: assert property (tx_start |=> tx_shifting_flag && !serial_tx_out)
      else $error("shifter not running after load");
   low_read_a: assert property (rd_acc && hit_low |-> readdata[31:8] == '0)
      else $error("low data read upper bits not zero");
   rx_irq_a: assert property (rx_done |=> receive_irq ##1 (!receive_irq || $past(rx_done)))
      else $error("receive interrupt not pulsed");
   rx_irq_src_a: assert property (receive_irq |-> $past(rx_done))
      else $error("receive interrupt without a byte");
   tx_irq_src_a: assert property (transmit_irq |-> $past(tx_start))
      else $error("transmit interrupt without a load");
   tx_irq_a: assert property (tx_start |=> transmit_irq && !tx_full_flag)
      else $error("transmit interrupt or empty missing");
   div_reset_a: assert property ($fell(rst) |-> bit_rate_divider == DIV_RESET)
      else $error("divider not zero after reset");
   status_high_a: assert property (rd_acc && hit_status |-> readdata[31:4] == '0)
      else $error("status upper bits not zero");
   line_idle_a: assert property (!tx_shifting_flag |-> serial_tx_out)
      else $error("line not high while idle");
   held_send_a: assert property (tx_full_flag && !tx_shifting_flag |-> tx_start)
      else $error("held byte not sent when shifter free");
   held_keep_a: assert property (tx_full_flag && !tx_start |=> tx_full_flag && tx_hold == $past(tx_hold))
      else $error("held byte lost before its frame");
   tx_full_view_a: assert property (rd_acc && hit_status |-> readdata[ST_TX_FULL] == $past(tx_full_flag))
      else $error("transmit full not shown in status");
   shift_view_a: assert property (rd_acc && hit_status |-> readdata[ST_TX_SHIFT] == $past(tx_shifting_flag))
      else $error("shifter state not shown in status");
   rx_full_view_a: assert property (rd_acc && hit_status |-> readdata[ST_RX_FULL] == $past(rx_full_flag))
      else $error("receive full not shown in status");
   orun_view_a: assert property (rd_acc && hit_status |-> readdata[ST_RX_ORUN] == $past(rx_overrun_flag))
      else $error("overrun not shown in status");
   low_data_a: assert property (rd_acc && hit_low |-> readdata[7:0] == $past(rx_data))
      else $error("low data read byte wrong");
   high_read_a: assert property (rd_acc && hit_high |-> readdata == {16'h0000, $past(rx_data), 8'h00})
      else $error("high data read layout wrong");
   rx_clear_a: assert property (data_rd && !rx_done && !rx_stale |=> !rx_full_flag)
      else $error("data read did not clear receive full");
   rx_hold_a: assert property (!rx_done |=> rx_data == $past(rx_data))
      else $error("receive data changed without a good frame");
   orun_hold_a: assert property (!rx_done |=> rx_overrun_flag == $past(rx_overrun_flag))
      else $error("overrun changed without a good frame");
   div_write_a: assert property (wr_acc && hit_div && byteenable[1:0] == 2'b11 |=>
      bit_rate_divider == $past(writedata[15:0]))
      else $error("divider write not stored");
endmodule

/* File: dv/dsp_remote_port.sv */
`timescale 1ns/100ps
module dsp_remote_port
(
   // Bench clock
   input wire logic ref_clk,
   // Line from the device, line to the device
   input wire logic line_in,
   output logic line_out,
   // Clocks per bit, (D1+1)*D2
   input wire logic [15:0] bit_clocks,
   // Last byte heard and how many
   output logic [7:0] rx_byte,
   output logic [7:0] rx_count,
   output logic frame_err
);
   // Bits collected LSB first
   logic [7:0] shreg;
   int i;

   initial
   begin
      line_out = 1'b1;
      rx_byte = 8'h00;
      rx_count = 8'h00;
      frame_err = 1'b0;
      shreg = 8'h00;
   end

   ////////////////////////////////////////
   // Sends one frame after an idle gap; stop may be broken on purpose
   task automatic send_frame(input logic [7:0] b, input logic stop_ok, input int gap_bits);
      int k;
      repeat (gap_bits * bit_clocks) @(posedge ref_clk);
      line_out <= 1'b0;
      repeat (bit_clocks) @(posedge ref_clk);
      for (k = 0; k < 8; k++)
      begin
         line_out <= b[k];
         repeat (bit_clocks) @(posedge ref_clk);
      end
      // A low stop only when the test asks for one
      line_out <= stop_ok;
      repeat (bit_clocks) @(posedge ref_clk);
      line_out <= 1'b1;
      // One edge of idle so a following frame never assigns twice
      @(posedge ref_clk);
   endtask

   ////////////////////////////////////////
   // Listener: sampled on the falling edge, away from the device's updates
   always
   begin
      @(negedge ref_clk);
      if (line_in === 1'b0)
      begin
         // Mid start bit, then mid of every bit
         repeat (bit_clocks / 2) @(negedge ref_clk);
         if (line_in !== 1'b0)
            frame_err = 1'b1;
         for (i = 0; i < 8; i++)
         begin
            repeat (bit_clocks) @(negedge ref_clk);
            shreg[i] = line_in;
         end
         repeat (bit_clocks) @(negedge ref_clk);
         if (line_in !== 1'b1)
            frame_err = 1'b1;
         rx_byte = shreg;
         rx_count = rx_count + 8'h01;
      end
   end
endmodule

/* File: dv/dsp_serial_tb_top.sv */
`timescale 1ns/100ps
module dsp_serial_tb_top
   import dsp_pkg::*;
;
   // Clock, reset and bus
   logic ref_clk;
   logic rst;
   logic [ADDR_W-1:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   // Serial lines and interrupts
   logic serial_rx_in;
   logic serial_tx_out;
   logic transmit_irq;
   logic receive_irq;
   // Remote side results
   logic [7:0] rx_byte;
   logic [7:0] rx_count;
   logic frame_err;
   // Twelve clocks a bit: D1=1, D2=6
   logic [15:0] bit_clocks;
   logic [7:0] tx_irqs;
   logic [7:0] rx_irqs;
   logic [31:0] rd;
   int bad_count;
   int checks;

   `define CHECK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

   dsp_serial dut (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
      .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out), .transmit_irq(transmit_irq),
      .receive_irq(receive_irq));

   dsp_remote_port port (.ref_clk(ref_clk), .line_in(serial_tx_out), .line_out(serial_rx_in),
      .bit_clocks(bit_clocks), .rx_byte(rx_byte), .rx_count(rx_count), .frame_err(frame_err));

   ////////////////////////////////////////
   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Pulse counters, read mid-cycle where the pulses are settled
   always @(negedge ref_clk)
   begin
      if (rst === 1'b1)
      begin
         tx_irqs = 8'h00;
         rx_irqs = 8'h00;
      end
      else
      begin
         if (transmit_irq === 1'b1)
            tx_irqs = tx_irqs + 8'h01;
         if (receive_irq === 1'b1)
            rx_irqs = rx_irqs + 8'h01;
      end
   end

   ////////////////////////////////////////
   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One Avalon access; held until waitrequest is seen low at an edge
   task automatic bus_cycle(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
      output logic [31:0] rdata);
      logic got;
      got = 1'b0;
      rdata = 32'h0000_0000;
      @(posedge ref_clk);
      address <= {idx, 2'b00};
      read <= !wr;
      write <= wr;
      writedata <= wd;
      // No cycle count assumed; a hang is left to the watchdog
      while (!got)
      begin
         // Read before this edge's updates land, as the slave samples it
         @(posedge ref_clk);
         got = (waitrequest === 1'b0);
      end
      // Read data taken at the accepting edge, then the request drops
      rdata = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // Read and compare
   task automatic chk_reg(input logic [15:0] idx, input logic [31:0] exp, input string nm);
      logic [31:0] v;
      bus_cycle(idx, 1'b0, 32'h0000_0000, v);
      `CHECK(nm, exp, v)
   endtask

   // Bounded wait for the remote side to hear a byte count
   task automatic wait_rx(input logic [7:0] cnt);
      int n;
      n = 0;
      while (rx_count !== cnt && n < 2000)
      begin
         @(posedge ref_clk);
         n++;
      end
      `CHECK("remote count", cnt, rx_count)
   endtask

   ////////////////////////////////////////
   // Watchdog, far beyond the nine hundred or so cycles the tests need
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      summarize();
   end

   ////////////////////////////////////////
   // Tests
   initial
   begin
      bad_count = 0;
      checks = 0;
      rst = 1'b1;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      bit_clocks = 16'h000C;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, status write, unmapped place
      chk_reg(IDX_DIVIDER, 32'h0000_0000, "divider reset");
      chk_reg(IDX_STATUS, 32'h0000_0000, "status reset");
      bus_cycle(IDX_STATUS, 1'b1, 32'hFFFF_FFFF, rd);
      chk_reg(IDX_STATUS, 32'h0000_0000, "status after write");
      chk_reg(16'hC02C, 32'h0000_0000, "unmapped");
      bus_cycle(IDX_DIVIDER, 1'b1, 32'h0000_0106, rd);
      chk_reg(IDX_DIVIDER, 32'h0000_0106, "divider");
      // Transmit: idle write goes straight out, second is held
      bus_cycle(IDX_DATA_LOW, 1'b1, 32'hFFFF_A5C3, rd);
      // The pulse follows the accepting edge and is counted mid-cycle
      @(posedge ref_clk);
      `CHECK("tx irq at start", 8'h01, tx_irqs)
      chk_reg(IDX_STATUS, 32'h0000_0001, "status shifting");
      // Status showed the transmit register empty, so this write is allowed
      bus_cycle(IDX_DATA_HIGH, 1'b1, 32'h0000_5AEE, rd);
      chk_reg(IDX_STATUS, 32'h0000_0003, "status held");
      wait_rx(8'h01);
      `CHECK("first byte", 8'hC3, rx_byte)
      wait_rx(8'h02);
      `CHECK("second byte", 8'h5A, rx_byte)
      `CHECK("tx irqs", 8'h02, tx_irqs)
      repeat (16) @(posedge ref_clk);
      chk_reg(IDX_STATUS, 32'h0000_0000, "status tx idle");
      `CHECK("frame shape", 1'b0, frame_err)
      // Receive, overrun, broken stop, reads
      port.send_frame(8'h3C, 1'b1, 1);
      repeat (4) @(posedge ref_clk);
      `CHECK("rx irq one", 8'h01, rx_irqs)
      chk_reg(IDX_STATUS, 32'h0000_0004, "status full");
      port.send_frame(8'h81, 1'b1, 2);
      repeat (4) @(posedge ref_clk);
      chk_reg(IDX_STATUS, 32'h0000_000C, "status overrun");
      port.send_frame(8'hA7, 1'b0, 1);
      repeat (4) @(posedge ref_clk);
      `CHECK("rx irq bad stop", 8'h02, rx_irqs)
      chk_reg(IDX_STATUS, 32'h0000_000C, "status bad stop");
      chk_reg(IDX_DATA_HIGH, 32'h0000_8100, "data high");
      chk_reg(IDX_STATUS, 32'h0000_0008, "status read");
      port.send_frame(8'h0F, 1'b1, 1);
      repeat (4) @(posedge ref_clk);
      chk_reg(IDX_STATUS, 32'h0000_0004, "status no overrun");
      chk_reg(IDX_DATA_LOW, 32'h0000_000F, "data low");
      chk_reg(IDX_STATUS, 32'h0000_0000, "status empty");
      summarize();
   end
endmodule
